//--- design/adcc_top.v
// Converter control: APB registers, channel sequencer, result
// register with overrun, DMA handshake and result-ready interrupt.
// Assumes an external analog cell that samples while cellSample is
// high and converts while cellConvert is high, code on cellData.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.vh"

module adcc_top #(
    parameter NCH = 8,
    parameter CHW = 3
) (
    input  wire           mclk,
    input  wire           sys_rst,
    input  wire [7:0]     paddr,
    input  wire           psel,
    input  wire           penable,
    input  wire           pwrite,
    input  wire [31:0]    pwdata,
    output reg  [31:0]    prdata,
    output wire           pready,
    output wire           pslverr,
    input  wire           trigPin,
    input  wire [9:0]     cellData,
    output reg            cellOn,
    output reg            cellSample,
    output reg            cellConvert,
    output reg  [CHW-1:0] cellChan,
    output wire           dmaReq,
    input  wire           dmaAck,
    output reg  [15:0]    dmaData,
    output wire           irq,
    output reg            clkReq
);
    localparam S_IDLE = 3'h0;
    localparam S_SU   = 3'h1;
    localparam S_SH   = 3'h2;
    localparam S_CONV = 3'h3;

    // Lowest enabled channel at or above a start index
    function [CHW:0] nextChan;
        input [NCH-1:0] mask;
        input [CHW:0]   from;
        integer i;
        begin
            nextChan = {1'b0, {CHW{1'b0}}};
            for (i = NCH - 1; i >= 0; i = i - 1)
                if (mask[i] && (i >= from))
                    nextChan = {1'b1, i[CHW-1:0]};
        end
    endfunction

    // Address match used by write decode, error decode and the latest-result read strobe
    function isReg;
        input [7:0] a;
        input [7:0] ofs;
        begin
            isReg = (a == ofs);
        end
    endfunction

    reg            enable_r;
    reg            autoTrig_r;
    reg [31:0]     cfg_r;
    reg [NCH-1:0]  chanOn_r;
    reg [11:0]     result_r;
    reg [CHW-1:0]  resChan_r;
    reg            pending_r;
    reg            overrun_r;
    reg [1:0]      ien_r;
    reg [1:0]      istat_r;
    reg [2:0]      state_r;
    reg [9:0]      cnt_r;
    reg [3:0]      sampCnt_r;
    reg            startReq_r;
    reg            trigS1;
    reg            trigS2;
    reg            trigPrev_r;

    wire [1:0] res     = cfg_r[`ADCC_CFG_RES_LO+1:`ADCC_CFG_RES_LO];
    wire       sleepEn = cfg_r[`ADCC_CFG_SLEEP];
    wire [5:0] div     = cfg_r[`ADCC_CFG_DIV_LO+5:`ADCC_CFG_DIV_LO];
    wire [3:0] shTicks = cfg_r[`ADCC_CFG_SH_LO+3:`ADCC_CFG_SH_LO];
    wire [6:0] suField = cfg_r[`ADCC_CFG_SU_LO+6:`ADCC_CFG_SU_LO];
    wire [9:0] suLast  = {suField, 3'h7};

    // APB phases; the slave never inserts wait states
    wire setup  = psel && !penable;
    wire access = psel && penable;
    wire wrAcc  = access && pwrite;
    wire rdAcc  = access && !pwrite;
    wire mapped = isReg(paddr, `ADCC_CTRL_OFS) || isReg(paddr, `ADCC_TRIG_OFS)
               || isReg(paddr, `ADCC_CFG_OFS) || isReg(paddr, `ADCC_CHON_OFS)
               || isReg(paddr, `ADCC_CHOFF_OFS) || isReg(paddr, `ADCC_CHSTAT_OFS)
               || isReg(paddr, `ADCC_LATEST_OFS) || isReg(paddr, `ADCC_STATUS_OFS)
               || isReg(paddr, `ADCC_IEN_OFS) || isReg(paddr, `ADCC_IDIS_OFS)
               || isReg(paddr, `ADCC_IMASK_OFS) || isReg(paddr, `ADCC_ISTAT_OFS)
               || isReg(paddr, `ADCC_ICLR_OFS);
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    wire wrCtrl = wrAcc && isReg(paddr, `ADCC_CTRL_OFS);
    wire wrIclr = wrAcc && isReg(paddr, `ADCC_ICLR_OFS);
    wire rdLast = rdAcc && isReg(paddr, `ADCC_LATEST_OFS);

    wire tick;
    wire busy  = (state_r != S_IDLE);
    wire [CHW:0] firstCh = nextChan(chanOn_r, {(CHW+1){1'b0}});
    wire [CHW:0] afterCh = nextChan(chanOn_r, {1'b0, cellChan} + 1'b1);
    wire [3:0] sampLast  = (res == `ADCC_RES12) ? 4'hF :
                           (res == `ADCC_RES11) ? 4'h3 : 4'h0;
    wire convDone  = (state_r == S_CONV) && tick
                  && (cnt_r == {6'h00, `ADCC_CONV_TICKS} - 10'h001);
    wire resultNow = convDone && (sampCnt_r == sampLast);
    wire [11:0] avgValue;

    adcc_clkdiv #(.DW(6)) uDiv (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .run     (busy),
        .div     (div),
        .tick    (tick)
    );

    adcc_avg uAvg (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (!busy || resultNow),
        .add     (convDone),
        .res     (res),
        .raw     (cellData),
        .value   (avgValue)
    );

    // Trigger pin synchroniser; edge taken after the second stage
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            trigS1     <= 1'b0;
            trigS2     <= 1'b0;
            trigPrev_r <= 1'b0;
        end
        else
        begin
            trigS1     <= trigPin;
            trigS2     <= trigS1;
            trigPrev_r <= trigS2;
        end
    end

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            enable_r   <= 1'b0;
            autoTrig_r <= 1'b0;
            cfg_r      <= `ADCC_CFG_RST;
            chanOn_r   <= {NCH{1'b0}};
            ien_r      <= 2'h0;
        end
        else if (wrAcc)
        begin
            if (isReg(paddr, `ADCC_CTRL_OFS))
                enable_r <= pwdata[`ADCC_CTRL_EN];
            if (isReg(paddr, `ADCC_TRIG_OFS))
                autoTrig_r <= pwdata[0];
            if (isReg(paddr, `ADCC_CFG_OFS))
                cfg_r <= pwdata;
            if (isReg(paddr, `ADCC_CHON_OFS))
                chanOn_r <= chanOn_r | pwdata[NCH-1:0];
            if (isReg(paddr, `ADCC_CHOFF_OFS))
                chanOn_r <= chanOn_r & ~pwdata[NCH-1:0];
            if (isReg(paddr, `ADCC_IEN_OFS))
                ien_r <= ien_r | pwdata[1:0];
            if (isReg(paddr, `ADCC_IDIS_OFS))
                ien_r <= ien_r & ~pwdata[1:0];
        end
    end

    // start request held until the sequencer is idle; taken there only if a channel is on
    always @(posedge mclk)
    begin
        if (sys_rst || !enable_r)
            startReq_r <= 1'b0;
        else if ((wrCtrl && pwdata[`ADCC_CTRL_START])
                 || (autoTrig_r && trigS2 && !trigPrev_r))
            startReq_r <= 1'b1;
        else if (!busy)
            startReq_r <= 1'b0;
    end

    // Channel sequencer; disabling aborts, no tick means halt in place
    // only reset, enable and clock stop it, not debug
    always @(posedge mclk)
    begin
        if (sys_rst || !enable_r)
        begin
            state_r     <= S_IDLE;
            cnt_r       <= 10'h000;
            sampCnt_r   <= 4'h0;
            cellChan    <= {CHW{1'b0}};
            cellOn      <= 1'b0;
            cellSample  <= 1'b0;
            cellConvert <= 1'b0;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (startReq_r && firstCh[CHW])
                    begin
                        cellChan  <= firstCh[CHW-1:0];
                        cnt_r     <= 10'h000;
                        sampCnt_r <= 4'h0;
                        cellOn    <= 1'b1;
                        if (!cellOn || sleepEn)
                            state_r <= S_SU;
                        else
                        begin
                            state_r    <= S_SH;
                            cellSample <= 1'b1;
                        end
                    end
                end
                S_SU:
                begin
                    // Startup in steps of eight ticks
                    if (tick)
                    begin
                        if (cnt_r == suLast)
                        begin
                            cnt_r      <= 10'h000;
                            state_r    <= S_SH;
                            cellSample <= 1'b1;
                        end
                        else
                            cnt_r <= cnt_r + 10'h001;
                    end
                end
                S_SH:
                begin
                    if (tick)
                    begin
                        if (cnt_r[3:0] == shTicks)
                        begin
                            cnt_r       <= 10'h000;
                            state_r     <= S_CONV;
                            cellSample  <= 1'b0;
                            cellConvert <= 1'b1;
                        end
                        else
                            cnt_r <= cnt_r + 10'h001;
                    end
                end
                S_CONV:
                begin
                    if (convDone)
                    begin
                        cnt_r       <= 10'h000;
                        cellConvert <= 1'b0;
                        if (!resultNow)
                        begin
                            sampCnt_r  <= sampCnt_r + 4'h1;
                            state_r    <= S_SH;
                            cellSample <= 1'b1;
                        end
                        else if (afterCh[CHW] && (cellChan != NCH - 1))
                        begin
                            sampCnt_r  <= 4'h0;
                            cellChan   <= afterCh[CHW-1:0];
                            state_r    <= S_SH;
                            cellSample <= 1'b1;
                        end
                        else
                        begin
                            state_r <= S_IDLE;
                            cellOn  <= !sleepEn;
                        end
                    end
                    else if (tick)
                        cnt_r <= cnt_r + 10'h001;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // Result register and its unread flag; a new result wins over a read
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            result_r  <= 12'h000;
            resChan_r <= {CHW{1'b0}};
            pending_r <= 1'b0;
            dmaData   <= 16'h0000;
        end
        else if (resultNow)
        begin
            result_r  <= avgValue;
            resChan_r <= cellChan;
            pending_r <= 1'b1;
            // low half-word holds the whole code
            dmaData   <= {4'h0, avgValue};
        end
        else if (rdLast || dmaAck)
            pending_r <= 1'b0;
    end

    // Sticky flags; hardware set wins over software clear
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            overrun_r <= 1'b0;
            istat_r   <= 2'h0;
        end
        else
        begin
            // overwrite of unread result, CPU or DMA
            if (resultNow && pending_r && !rdLast && !dmaAck)
                overrun_r <= 1'b1;
            else if (wrIclr && pwdata[`ADCC_ST_OVR])
                overrun_r <= 1'b0;
            // DMA read clears it in hardware
            if (resultNow)
                istat_r[`ADCC_ST_RESULT_READY_FLAG] <= 1'b1;
            else if ((wrIclr && pwdata[`ADCC_ST_RESULT_READY_FLAG]) || dmaAck)
                istat_r[`ADCC_ST_RESULT_READY_FLAG] <= 1'b0;
            if (resultNow && pending_r && !rdLast && !dmaAck)
                istat_r[`ADCC_ST_OVR] <= 1'b1;
            else if (wrIclr && pwdata[`ADCC_ST_OVR])
                istat_r[`ADCC_ST_OVR] <= 1'b0;
        end
    end

    // DMA request while a result waits unread
    assign dmaReq = pending_r;
    assign irq = |(istat_r & ien_r);

    // keep the local clock requested while work is pending
    always @(posedge mclk)
    begin
        if (sys_rst)
            clkReq <= 1'b0;
        else
            clkReq <= busy || startReq_r || pending_r;
    end

    // Read data captured in setup so it stands through access
    always @(posedge mclk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `ADCC_CTRL_OFS:   prdata[`ADCC_CTRL_EN] <= enable_r;
                `ADCC_TRIG_OFS:   prdata[0] <= autoTrig_r;
                `ADCC_CFG_OFS:    prdata <= cfg_r;
                `ADCC_CHSTAT_OFS: prdata[NCH-1:0] <= chanOn_r;
                `ADCC_LATEST_OFS: prdata <= {{(16-CHW){1'b0}}, resChan_r,
                                             4'h0, result_r};
                `ADCC_STATUS_OFS: prdata[2:0] <= {busy, overrun_r, pending_r};
                `ADCC_IMASK_OFS:  prdata[1:0] <= ien_r;
                `ADCC_ISTAT_OFS:  prdata[1:0] <= istat_r;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- design/adcc_defines.vh
// Constants of the converter control block: register map, field
// positions, reset values and conversion timing.
// Assumes APB word addressing with byte offsets below.
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// Register byte offsets
`define ADCC_CTRL_OFS      8'h00
`define ADCC_TRIG_OFS      8'h04
`define ADCC_CFG_OFS       8'h08
`define ADCC_CHON_OFS      8'h10
`define ADCC_CHOFF_OFS     8'h14
`define ADCC_CHSTAT_OFS    8'h18
`define ADCC_LATEST_OFS    8'h1C
`define ADCC_STATUS_OFS    8'h20
`define ADCC_IEN_OFS       8'h24
`define ADCC_IDIS_OFS      8'h28
`define ADCC_IMASK_OFS     8'h2C
`define ADCC_ISTAT_OFS     8'h30
`define ADCC_ICLR_OFS      8'h34

// Control bits
`define ADCC_CTRL_EN       0
`define ADCC_CTRL_START    1
// Config fields
`define ADCC_CFG_RES_LO    0
`define ADCC_CFG_SLEEP     4
`define ADCC_CFG_DIV_LO    8
`define ADCC_CFG_SH_LO     16
`define ADCC_CFG_SU_LO     24
`define ADCC_CFG_RST       32'h0000_0000
// Status and interrupt bits
`define ADCC_ST_RESULT_READY_FLAG       0
`define ADCC_ST_OVR        1
`define ADCC_ST_BUSY       2
// Latest result layout
`define ADCC_LR_CH_LO      16

// Resolution codes
`define ADCC_RES8          2'h0
`define ADCC_RES10         2'h1
`define ADCC_RES11         2'h2
`define ADCC_RES12         2'h3

// Timing in conversion-clock ticks
`define ADCC_CONV_TICKS    4'hA
`define ADCC_SU_STEP       3

`endif

//--- design/adcc_clkdiv.v
// Conversion clock enable generator.
// Assumes one bus clock; emits a one-cycle tick every 2*(div+1) cycles.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.vh"

module adcc_clkdiv #(
    parameter DW = 6
) (
    input  wire          mclk,
    input  wire          sys_rst,
    input  wire          run,
    input  wire [DW-1:0] div,
    output reg           tick
);
    reg [DW:0] cnt_r;
    wire [DW:0] last = {div, 1'b1};

    // Period is 2*(div+1); parks at one so the first tick is a full period
    always @(posedge mclk)
    begin
        if (sys_rst || !run)
        begin
            cnt_r <= {{DW{1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
        else if (cnt_r >= last)
        begin
            cnt_r <= {(DW+1){1'b0}};
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- design/adcc_avg.v
// Sample accumulator for the enhanced resolution modes.
// Assumes raw 10-bit codes from the cell; result is scaled by resolution.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.vh"

module adcc_avg (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        clr,
    input  wire        add,
    input  wire [1:0]  res,
    input  wire [9:0]  raw,
    output reg  [11:0] value
);
    reg  [13:0] acc_r;
    wire [13:0] sum = acc_r + {4'h0, raw};

    // Accumulate; clear takes precedence over add at sequence edges
    always @(posedge mclk)
    begin
        if (sys_rst || clr)
            acc_r <= 14'h0000;
        else if (add)
            acc_r <= sum;
    end

    // Scaling: 4 samples keep 11 bits, 16 samples keep 12 bits
    always @*
    begin
        case (res)
            `ADCC_RES8:  value = {4'h0, raw[9:2]};
            `ADCC_RES10: value = {2'h0, raw};
            `ADCC_RES11: value = {1'b0, sum[11:1]};
            `ADCC_RES12: value = sum[13:2];
            default:     value = 12'h000;
        endcase
    end
endmodule
`default_nettype wire

//--- bench/adcc_far_model.sv
// Far side of the converter control: analog cell and one DMA channel.
// Assumes the bench switches the DMA on and sets its ack delay.
`timescale 1ns/1ns
`default_nettype none
module adcc_far_model (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       cellConvert,
    input  wire logic [2:0] cellChan,
    input  wire logic       dmaReq,
    input  wire logic       dmaOn,
    input  wire logic [7:0] dly,
    output logic      [9:0] cellData,
    output logic            dmaAck
);
    logic [7:0] cnt;
    logic [9:0] last = 10'h000;

    // Code fixed per channel; off phase toggles so nothing stale is seen
    always_comb
    begin
        cellData = cellConvert ? {cellChan, 7'h2B} : ~last;
    end

    always @(posedge mclk)
    begin
        last <= cellData;
        dmaAck <= !(sys_rst || dmaAck) && dmaOn && dmaReq && cnt == dly;
        if (sys_rst || dmaAck || !(dmaOn && dmaReq))
            cnt <= 8'h00;
        else if (cnt != dly)
            cnt <= cnt + 8'h01;
    end
endmodule
`default_nettype wire

//--- bench/adcc_top_checker.sv
// Property checker for the converter control top level.
// Assumes it is bound to adcc_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.vh"
module adcc_top_checker (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        cellSample,
    input wire logic        cellConvert,
    input wire logic        dmaReq,
    input wire logic        dmaAck,
    input wire logic [15:0] dmaData,
    input wire logic        irq,
    input wire logic        clkReq
);
    logic        enR;
    logic [31:0] cfgR;
    logic [11:0] convCnt;
    logic [11:0] sampCnt;
    wire  [11:0] tickLen = {5'h00, cfgR[13:8], 1'b0} + 12'h002;
    wire  [11:0] shLen = tickLen * ({8'h00, cfgR[19:16]} + 12'h001);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence apbWr(ofs);
        psel && penable && pwrite && paddr == ofs;
    endsequence

    // Shadows of enable and config, from completed writes
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            enR <= 1'b0;
            cfgR <= `ADCC_CFG_RST;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == `ADCC_CTRL_OFS)
                enR <= pwdata[0];
            if (paddr == `ADCC_CFG_OFS)
                cfgR <= pwdata;
        end
    end

    // Phase lengths in bus clocks; first sample may start mid tick
    always @(posedge mclk)
    begin
        convCnt <= (sys_rst || !cellConvert) ? 12'h000 : convCnt + 12'h001;
        sampCnt <= (sys_rst || !cellSample) ? 12'h000 : sampCnt + 12'h001;
    end

    idle_when_off_a: assert property (!enR [*3] |-> !cellSample && !cellConvert)
        else $error("converter busy while disabled");
    conv_length_a: assert property ($fell(cellConvert) && enR |-> convCnt == tickLen * 12'h00A)
        else $error("conversion phase length off");
    sample_length_a: assert property ($fell(cellSample) && enR |->
        sampCnt <= shLen && sampCnt + tickLen > shLen)
        else $error("sample phase length off");
    sample_then_conv_a: assert property ($fell(cellSample) && enR |-> cellConvert)
        else $error("no conversion after sample");
    req_with_result_a: assert property ($rose(dmaReq) |-> $fell(cellConvert))
        else $error("dma request without result");
    ack_clears_req_a: assert property (dmaAck && dmaReq |=> !dmaReq || $fell(cellConvert))
        else $error("dma request kept after ack");
    clear_drops_irq_a: assert property (apbWr(`ADCC_ICLR_OFS) ##0 pwdata[1:0] == 2'b11
        |=> !irq || $fell(cellConvert))
        else $error("interrupt kept after clear");
    low_res_zero_a: assert property (cfgR[1:0] == `ADCC_RES8 && dmaReq |-> dmaData[11:8] == 4'h0)
        else $error("upper bits set in 8-bit mode");
    clock_kept_a: assert property (cellConvert && $past(cellConvert) |-> clkReq)
        else $error("clock request low while converting");
endmodule

bind adcc_top adcc_top_checker chk (
    .mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .cellSample(cellSample), .cellConvert(cellConvert),
    .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaData(dmaData), .irq(irq), .clkReq(clkReq)
);
`default_nettype wire

//--- bench/adcc_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes the far-side model stands in for the cell and the DMA channel.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_defines.vh"
module adcc_top_tb;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        trigPin = 1'b0;
    logic        dmaOn = 1'b0;
    logic        prevConv = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  dly = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    wire  [31:0] prdata;
    wire  [15:0] dmaData;
    wire  [9:0]  cellData;
    wire  [2:0]  cellChan;
    wire         pready, pslverr, cellOn, cellSample, cellConvert;
    wire         dmaReq, dmaAck, irq, clkReq;
    logic [64:0] e;
    logic [5:0]  dv;
    logic [15:0] expQ[$];
    logic [64:0] rdQ[$];
    int          err_total = 0;
    int          tests_run = 0;
    int          convDone = 0;
    int          n0;
    integer      seed;

    adcc_top dut (
        .mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigPin(trigPin), .cellData(cellData), .cellOn(cellOn),
        .cellSample(cellSample), .cellConvert(cellConvert), .cellChan(cellChan),
        .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaData(dmaData), .irq(irq), .clkReq(clkReq)
    );
    adcc_far_model far (
        .mclk(mclk), .sys_rst(sys_rst), .cellConvert(cellConvert), .cellChan(cellChan),
        .dmaReq(dmaReq), .dmaOn(dmaOn), .dly(dly), .cellData(cellData), .dmaAck(dmaAck)
    );

    // Result expected from the model's fixed code per channel
    function automatic logic [15:0] expOf(input logic [1:0] r, input logic [2:0] ch);
        logic [15:0] raw;
        begin
            raw = {6'h00, ch, 7'h2B};
            case (r)
                2'h0: expOf = {8'h00, raw[9:2]};
                2'h1: expOf = raw;
                2'h2: expOf = raw << 1;
                default: expOf = raw << 2;
            endcase
        end
    endfunction

    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        err_total++;
    endtask

    task automatic check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
            fail(m);
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; the watcher compares its answer
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] m);
        int          n;
        logic [31:0] mm;
        mm = wr ? 32'h0000_0000 : m;
        rdQ.push_back({(a > `ADCC_ICLR_OFS || a == 8'h0C), mm, d & mm});
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            fail("no ready");
            stop_test;
        end
    endtask

    // Negative want waits for the DMA notes to drain
    task automatic waitFor(input int want);
        int n;
        n = 0;
        while ((want < 0 ? expQ.size() != 0 : convDone < want) && n < 40000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 40000)
        begin
            fail("timeout");
            stop_test;
        end
        repeat (8) @(posedge mclk);
    endtask

    task automatic expect3(input logic [1:0] r);
        expQ.push_back(expOf(r, 3'h1));
        expQ.push_back(expOf(r, 3'h3));
        expQ.push_back(expOf(r, 3'h6));
    endtask

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // Watcher: completions compared against the oldest note
    always @(posedge mclk)
    begin
        prevConv <= cellConvert;
        if (prevConv && !cellConvert)
            convDone <= convDone + 1;
        if (psel && penable && pready && rdQ.size() > 0)
        begin
            e = rdQ.pop_front();
            check(((prdata & e[63:32]) === e[31:0]) && (pslverr === e[64]), "apb answer");
        end
        if (dmaAck && dmaReq && expQ.size() > 0)
            check(dmaData === expQ.pop_front(), "dma result");
    end

    initial
    begin
        seed = 68;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        xfer(0, `ADCC_CTRL_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
        xfer(0, `ADCC_CFG_OFS, `ADCC_CFG_RST, 32'hFFFF_FFFF);
        xfer(1, 8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
        xfer(0, 8'hFC, 32'h0000_0000, 32'hFFFF_FFFF);
        xfer(1, `ADCC_CHON_OFS, 32'h0000_0001, 32'h0000_0000);
        xfer(1, `ADCC_CTRL_OFS, 32'h0000_0002, 32'h0000_0000);
        repeat (200) @(posedge mclk);
        xfer(0, `ADCC_STATUS_OFS, 32'h0000_0000, 32'h0000_0007);
        xfer(1, `ADCC_CTRL_OFS, 32'h0000_0001, 32'h0000_0000);
        xfer(1, `ADCC_CHOFF_OFS, 32'h0000_00FF, 32'h0000_0000);
        xfer(1, `ADCC_CHON_OFS, 32'h0000_004A, 32'h0000_0000);
        xfer(0, `ADCC_CHSTAT_OFS, 32'h0000_004A, 32'h0000_00FF);
        dmaOn <= 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            dv = 6'($random(seed) & 3);
            dly <= 8'($random(seed) & 3);
            xfer(1, `ADCC_CFG_OFS, {16'h0000, 2'b00, dv, 6'h00, 2'(r)}, 32'h0000_0000);
            expect3(2'(r));
            xfer(1, `ADCC_CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
            waitFor(-1);
        end
        xfer(0, `ADCC_ISTAT_OFS, 32'h0000_0000, 32'h0000_0003);
        xfer(1, `ADCC_CFG_OFS, 32'h0000_3F01, 32'h0000_0000);
        xfer(1, `ADCC_TRIG_OFS, 32'h0000_0001, 32'h0000_0000);
        expect3(`ADCC_RES10);
        trigPin <= 1'b1;
        repeat (8) @(posedge mclk);
        trigPin <= 1'b0;
        waitFor(-1);
        xfer(1, `ADCC_TRIG_OFS, 32'h0000_0000, 32'h0000_0000);
        xfer(1, `ADCC_CFG_OFS, 32'h0000_0011, 32'h0000_0000);
        dly <= 8'h3C;
        xfer(1, `ADCC_CHOFF_OFS, 32'h0000_00FF, 32'h0000_0000);
        xfer(1, `ADCC_CHON_OFS, 32'h0000_0024, 32'h0000_0000);
        expQ.push_back(expOf(`ADCC_RES10, 3'h5));
        xfer(1, `ADCC_CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
        waitFor(-1);
        xfer(0, `ADCC_STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
        xfer(1, `ADCC_ICLR_OFS, 32'h0000_0003, 32'h0000_0000);
        xfer(0, `ADCC_STATUS_OFS, 32'h0000_0000, 32'h0000_0002);
        dmaOn <= 1'b0;
        xfer(1, `ADCC_CHON_OFS, 32'h0000_0003, 32'h0000_0000);
        xfer(1, `ADCC_CHOFF_OFS, 32'h0000_0024, 32'h0000_0000);
        xfer(1, `ADCC_IEN_OFS, 32'h0000_0001, 32'h0000_0000);
        n0 = convDone;
        xfer(1, `ADCC_CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
        waitFor(n0 + 2);
        xfer(0, `ADCC_STATUS_OFS, 32'h0000_0003, 32'h0000_0003);
        @(negedge mclk);
        check(irq === 1'b1 && cellOn === 1'b0, "irq or cell state");
        xfer(0, `ADCC_LATEST_OFS, 32'h0001_00AB, 32'h0007_0FFF);
        xfer(1, `ADCC_ICLR_OFS, 32'h0000_0003, 32'h0000_0000);
        @(negedge mclk);
        check(irq === 1'b0, "irq not cleared");
        xfer(0, `ADCC_STATUS_OFS, 32'h0000_0000, 32'h0000_0003);
        @(negedge mclk);
        check(expQ.size() == 0 && rdQ.size() == 0, "notes left over");
        stop_test;
    end
endmodule
`default_nettype wire
